// ---- src/ccpc_pkg.sv ----
package ccpc_pkg;

	localparam logic [11:0] ADDR_CH2_VALUE_LO = 12'hfa5;
	localparam logic [11:0] ADDR_CH2_VALUE_HI = 12'hfa6;
	localparam logic [11:0] ADDR_CH2_CONTROL  = 12'hfa7;
	localparam logic [11:0] ADDR_CH2_CAPSRC   = 12'hfa8;
	localparam logic [11:0] ADDR_CH1_VALUE_LO = 12'hfa9;
	localparam logic [11:0] ADDR_CH1_VALUE_HI = 12'hfaa;
	localparam logic [11:0] ADDR_CH1_CONTROL  = 12'hfab;
	localparam logic [11:0] ADDR_CH1_CAPSRC   = 12'hfac;
	localparam logic [11:0] ADDR_TIMER_SEL    = 12'hfad;

	localparam int CTRL_EN_BIT  = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_FMT_BIT = 4;

	localparam logic [7:0]  RESET_TIMER_SEL = 8'h55;
	localparam logic [15:0] RESET_VALUE     = 16'h0000;
	localparam logic [3:0]  RESET_MODE      = 4'h0;
	localparam logic [3:0]  RESET_CAPSRC    = 4'h0;

	localparam logic [3:0] MODE_OFF        = 4'h0;
	localparam logic [3:0] MODE_TOGGLE_CLR = 4'h1;
	localparam logic [3:0] MODE_TOGGLE     = 4'h2;
	localparam logic [3:0] MODE_CAP_EVERY  = 4'h3;
	localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_SET        = 4'h8;
	localparam logic [3:0] MODE_CLEAR      = 4'h9;
	localparam logic [3:0] MODE_PULSE      = 4'ha;
	localparam logic [3:0] MODE_PULSE_CLR  = 4'hb;

	localparam logic [3:0] CAP_DIV4_LAST  = 4'h3;
	localparam logic [3:0] CAP_DIV16_LAST = 4'hf;

	localparam logic [3:0] SRC_PIN  = 4'h0;
	localparam logic [3:0] SRC_CMP1 = 4'h1;
	localparam logic [3:0] SRC_CMP2 = 4'h2;
	localparam logic [3:0] SRC_IOC  = 4'h3;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] period;
		logic [1:0] sub;
		logic       inc;
	} ccpc_tmr8_type;

	typedef struct packed {
		logic [15:0] value;
		logic        en;
		logic        fmt;
		logic [3:0]  mode;
		logic [3:0]  capsrc;
		logic        out;
		logic [9:0]  duty;
		logic [3:0]  pre;
		logic        prev;
		logic        mprev;
		logic        pulse;
		logic        flag;
	} ccpc_chan_type;

	typedef struct packed {
		ccpc_chan_type [1:0] ch;
		logic [7:0]          tsel;
		logic [3:0]          sync1;
		logic [3:0]          sync2;
		logic [7:0]          rdata;
		logic [2:0]          clr16;
		logic [2:0]          clr8;
	} ccpc_state_type;

endpackage

// ---- src/ccpc_unit.sv ----
// What this block does
// - Unit acts only while control bit 7 is one.
// - Control bit 5 reads the output level; writes to it do nothing.
// - In PWM, control bit 4 picks left or right duty alignment.
// - Modes 0101, 0100, 0011 capture on rise, fall, any edge; flag set.
// - Modes 0111, 0110 capture every sixteenth or fourth rising edge.
// - Modes 1000, 1001 set or clear output on match; mode 0000 resets it.
// - Mode 1010 pulses output on match; 1011 also clears the timer.
// - Mode 0010 toggles on match; 0001 also clears the timer; flag set.
// - Capture source: pin, comparators, change event, logic cells 1 to 8.
// - Capture and compare expose value as high and low bytes.
// - Right aligned PWM: high bits 1:0 and low byte form the duty.
// - Left aligned PWM: high byte and low bits 7:6 form the duty.
// - Standalone PWM timer select: 01 timer 2, 10 timer 4, 11 timer 6.
// - Channel timer select pairs timers 1/2, 3/4 or 5/6.
// - Reset restores register defaults and releases the pins.
// - PWM period end clears timer, sets output unless duty zero, buffers duty.
// - PWM output clears when the 10-bit time base equals buffered duty.
//
// Local design decision: the plain strobed port.
module ccpc_unit (
	input  wire logic                    mclk_in,
	input  wire logic                    nrst_in,
	input  wire logic [11:0]             addr_in,
	input  wire logic [7:0]              wdata_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output logic      [7:0]              rdata_out,
	input  wire logic [2:0][15:0]        timer16_in,
	input  ccpc_pkg::ccpc_tmr8_type [2:0] timer8_in,
	input  wire logic [1:0]              pin_select_in,
	input  wire logic [1:0]              comparator_in,
	input  wire logic                    interrupt_on_change_in,
	input  wire logic [7:0]              logic_cell_in,
	output logic      [1:0]              unit_out_out,
	output logic      [1:0]              unit_oe_out,
	output logic      [1:0]              unit_interrupt_flag_out,
	output logic      [2:0]              timer16_clear_out,
	output logic      [2:0]              timer8_clear_out,
	output logic      [3:0]              pwm_timer_select_out
);

	ccpc_pkg::ccpc_state_type st;
	ccpc_pkg::ccpc_state_type next_st;

	// Helpers kept visible for the checks below
	logic [1:0]       cap_fire;
	logic [1:0]       match_fire;
	logic [1:0]       pwm_roll;
	logic [1:0][15:0] t16_sel;

	function automatic logic is_compare(input logic [3:0] m);
		return (m[3:2] == 2'b10) || (m == ccpc_pkg::MODE_TOGGLE)
			|| (m == ccpc_pkg::MODE_TOGGLE_CLR);
	endfunction

	function automatic logic is_capture(input logic [3:0] m);
		return (m >= ccpc_pkg::MODE_CAP_EVERY) && (m <= ccpc_pkg::MODE_CAP_RISE16);
	endfunction

	always_comb
	begin
		ccpc_pkg::ccpc_chan_type c;
		ccpc_pkg::ccpc_tmr8_type t8;
		logic [1:0]  tfield;
		logic [1:0]  tidx;
		logic        tvalid;
		logic        src;
		logic        rise;
		logic        fall;
		logic        match;
		logic [9:0]  duty_new;
		logic [11:0] a_lo;
		logic [11:0] a_hi;
		logic [11:0] a_ctl;
		logic [11:0] a_cap;
		c        = '0;
		t8       = '0;
		tfield   = 2'h0;
		tidx     = 2'h0;
		tvalid   = 1'b0;
		src      = 1'b0;
		rise     = 1'b0;
		fall     = 1'b0;
		match    = 1'b0;
		duty_new = 10'h000;
		a_lo     = 12'h000;
		a_hi     = 12'h000;
		a_ctl    = 12'h000;
		a_cap    = 12'h000;
		cap_fire   = 2'h0;
		match_fire = 2'h0;
		pwm_roll   = 2'h0;
		t16_sel    = '0;
		next_st       = st;
		next_st.sync1 = {comparator_in, pin_select_in};
		next_st.sync2 = st.sync1;
		next_st.clr16 = 3'h0;
		next_st.clr8  = 3'h0;
		next_st.rdata = 8'h00;
		for (int i = 0; i < 2; i++)
		begin
			c      = st.ch[i];
			c.flag = 1'b0;
			a_lo   = (i == 0) ? ccpc_pkg::ADDR_CH1_VALUE_LO : ccpc_pkg::ADDR_CH2_VALUE_LO;
			a_hi   = (i == 0) ? ccpc_pkg::ADDR_CH1_VALUE_HI : ccpc_pkg::ADDR_CH2_VALUE_HI;
			a_ctl  = (i == 0) ? ccpc_pkg::ADDR_CH1_CONTROL : ccpc_pkg::ADDR_CH2_CONTROL;
			a_cap  = (i == 0) ? ccpc_pkg::ADDR_CH1_CAPSRC : ccpc_pkg::ADDR_CH2_CAPSRC;
			// Reserved select 00 leaves the channel without a timer
			tfield = st.tsel[2*i +: 2];
			tvalid = (tfield != 2'b00);
			tidx   = tfield - 2'b01;
			t16_sel[i] = tvalid ? timer16_in[tidx] : 16'h0000;
			t8         = tvalid ? timer8_in[tidx] : '0;
			// Reserved source codes read as a quiet low input
			case (c.capsrc)
				ccpc_pkg::SRC_PIN:  src = st.sync2[i];
				ccpc_pkg::SRC_CMP1: src = st.sync2[2];
				ccpc_pkg::SRC_CMP2: src = st.sync2[3];
				ccpc_pkg::SRC_IOC:  src = interrupt_on_change_in;
				default:            src = c.capsrc[3] ? logic_cell_in[c.capsrc[2:0]] : 1'b0;
			endcase
			rise   = src && !c.prev;
			fall   = !src && c.prev;
			c.prev = src;
			if (c.pulse)
			begin
				c.out   = 1'b0;
				c.pulse = 1'b0;
			end
			if (c.en && is_capture(c.mode))
			begin
				case (c.mode)
					ccpc_pkg::MODE_CAP_EVERY: cap_fire[i] = rise || fall;
					ccpc_pkg::MODE_CAP_FALL:  cap_fire[i] = fall;
					ccpc_pkg::MODE_CAP_RISE:  cap_fire[i] = rise;
					ccpc_pkg::MODE_CAP_RISE4,
					ccpc_pkg::MODE_CAP_RISE16:
					begin
						if (rise)
						begin
							cap_fire[i] = (c.pre == ((c.mode == ccpc_pkg::MODE_CAP_RISE4) ?
								ccpc_pkg::CAP_DIV4_LAST : ccpc_pkg::CAP_DIV16_LAST));
							c.pre = cap_fire[i] ? 4'h0 : c.pre + 4'h1;
						end
					end
					default: cap_fire[i] = 1'b0;
				endcase
				if (cap_fire[i])
				begin
					c.value = t16_sel[i];
					c.flag  = 1'b1;
				end
			end
			match = c.en && tvalid && is_compare(c.mode) && (t16_sel[i] == c.value);
			match_fire[i] = match && !c.mprev;
			c.mprev = match;
			if (match_fire[i])
			begin
				c.flag = 1'b1;
				case (c.mode)
					ccpc_pkg::MODE_SET:   c.out = 1'b1;
					ccpc_pkg::MODE_CLEAR: c.out = 1'b0;
					ccpc_pkg::MODE_PULSE,
					ccpc_pkg::MODE_PULSE_CLR:
					begin
						c.out   = 1'b1;
						c.pulse = 1'b1;
					end
					default: c.out = !c.out;
				endcase
				if (c.mode == ccpc_pkg::MODE_PULSE_CLR || c.mode == ccpc_pkg::MODE_TOGGLE_CLR)
					next_st.clr16[tidx] = 1'b1;
			end
			if (c.en && c.mode[3:2] == 2'b11 && tvalid)
			begin
				duty_new = c.fmt ? {c.value[15:8], c.value[7:6]} : c.value[9:0];
				pwm_roll[i] = t8.inc && (t8.count == t8.period);
				if (pwm_roll[i])
				begin
					next_st.clr8[tidx] = 1'b1;
					c.duty = duty_new;
					c.out  = (duty_new != 10'h000);
					c.flag = 1'b1;
				end
				// The output is registered, so the clear is decided one step early
				else if (10'({t8.count, t8.sub} + 10'h001) == c.duty)
					c.out = 1'b0;
			end
			// A capture in the same cycle wins over a software value write
			if (wr_in && addr_in == a_lo && !cap_fire[i])
				c.value[7:0] = wdata_in;
			if (wr_in && addr_in == a_hi && !cap_fire[i])
				c.value[15:8] = wdata_in;
			if (wr_in && addr_in == a_ctl)
			begin
				c.en    = wdata_in[ccpc_pkg::CTRL_EN_BIT];
				c.fmt   = wdata_in[ccpc_pkg::CTRL_FMT_BIT];
				c.mode  = wdata_in[3:0];
				c.pre   = 4'h0;
				c.mprev = 1'b0;
				if (wdata_in[3:0] == ccpc_pkg::MODE_OFF)
				begin
					c.out   = 1'b0;
					c.pulse = 1'b0;
				end
			end
			if (wr_in && addr_in == a_cap)
				c.capsrc = wdata_in[3:0];
			if (rd_in && addr_in == a_lo)
				next_st.rdata = st.ch[i].value[7:0];
			if (rd_in && addr_in == a_hi)
				next_st.rdata = st.ch[i].value[15:8];
			if (rd_in && addr_in == a_ctl)
				next_st.rdata = {st.ch[i].en, 1'b0, st.ch[i].out, st.ch[i].fmt,
					st.ch[i].mode};
			if (rd_in && addr_in == a_cap)
				next_st.rdata = {4'h0, st.ch[i].capsrc};
			next_st.ch[i] = c;
		end
		if (wr_in && addr_in == ccpc_pkg::ADDR_TIMER_SEL)
			next_st.tsel = wdata_in;
		if (rd_in && addr_in == ccpc_pkg::ADDR_TIMER_SEL)
			next_st.rdata = st.tsel;
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			st      <= '0;
			st.tsel <= ccpc_pkg::RESET_TIMER_SEL;
			for (int i = 0; i < 2; i++)
			begin
				st.ch[i].value  <= ccpc_pkg::RESET_VALUE;
				st.ch[i].mode   <= ccpc_pkg::RESET_MODE;
				st.ch[i].capsrc <= ccpc_pkg::RESET_CAPSRC;
			end
		end
		else
			st <= next_st;
	end

	assign rdata_out            = st.rdata;
	assign timer16_clear_out    = st.clr16;
	assign timer8_clear_out     = st.clr8;
	assign pwm_timer_select_out = st.tsel[7:4];

	for (genvar g = 0; g < 2; g++)
	begin : g_pins
		assign unit_out_out[g]            = st.ch[g].out;
		assign unit_interrupt_flag_out[g] = st.ch[g].flag;
		// Pin stays an input unless the unit is enabled in a driving mode
		assign unit_oe_out[g] = st.ch[g].en && (is_compare(st.ch[g].mode)
			|| st.ch[g].mode[3:2] == 2'b11);
	end

	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);

	a_disabled_quiet: assert property (!st.ch[0].en && !(wr_in && addr_in == ccpc_pkg::ADDR_CH1_CONTROL)
		|=> !unit_interrupt_flag_out[0])
		else $error("disabled channel raised a flag");
	a_out_readback: assert property (rd_in && addr_in == ccpc_pkg::ADDR_CH1_CONTROL
		|=> rdata_out[5] == $past(st.ch[0].out) && rdata_out[6] == 1'b0)
		else $error("control read does not show output level");
	a_capture_copy: assert property (cap_fire[0]
		|=> unit_interrupt_flag_out[0] && st.ch[0].value == $past(t16_sel[0]))
		else $error("capture did not copy timer with flag");
	a_prescale_cap: assert property (cap_fire[0] && st.ch[0].mode == ccpc_pkg::MODE_CAP_RISE4
		|-> st.ch[0].pre == ccpc_pkg::CAP_DIV4_LAST)
		else $error("fourth edge capture on wrong edge");
	a_mode_off_reset: assert property (wr_in && addr_in == ccpc_pkg::ADDR_CH1_CONTROL
		&& wdata_in[3:0] == ccpc_pkg::MODE_OFF |=> !unit_out_out[0] ##1 !unit_interrupt_flag_out[0])
		else $error("mode zero did not reset output");
	a_pulse_clear: assert property (match_fire[0] && st.ch[0].mode == ccpc_pkg::MODE_PULSE_CLR
		&& st.tsel[1:0] == 2'b01 |=> timer16_clear_out[0] && unit_out_out[0] ##1 !unit_out_out[0])
		else $error("pulse and clear misbehaved");
	a_toggle_match: assert property (match_fire[0] && st.ch[0].mode == ccpc_pkg::MODE_TOGGLE
		&& !(wr_in && addr_in == ccpc_pkg::ADDR_CH1_CONTROL)
		|=> unit_out_out[0] != $past(unit_out_out[0]) && unit_interrupt_flag_out[0])
		else $error("toggle on match failed");
	a_pwm_period: assert property (pwm_roll[0] && !(wr_in && addr_in == ccpc_pkg::ADDR_CH1_CONTROL)
		|=> timer8_clear_out[$past(st.tsel[1:0]) - 2'b01]
		&& unit_out_out[0] == (st.ch[0].duty != 10'h000))
		else $error("PWM period end actions missing");
	a_pin_released: assert property (!st.ch[1].en |-> !unit_oe_out[1])
		else $error("pin driven while unit disabled");

	// Second channel carries most obligations of the first; no pulse-and-clear, falling edge or low byte checks
	a_ch2_quiet: assert property (
		!st.ch[1].en && !(wr_in && addr_in == ccpc_pkg::ADDR_CH2_CONTROL)
		|=> !unit_interrupt_flag_out[1]) else $error("disabled channel two raised a flag");
	a_ch2_readback: assert property (
		rd_in && addr_in == ccpc_pkg::ADDR_CH2_CONTROL
		|=> rdata_out[5] == $past(st.ch[1].out) && rdata_out[6] == 1'b0)
		else $error("channel two control read does not show output level");
	a_ch2_capture: assert property (
		cap_fire[1] |=> unit_interrupt_flag_out[1] && st.ch[1].value == $past(t16_sel[1]))
		else $error("channel two capture did not copy timer with flag");
	a_ch2_toggle: assert property (
		match_fire[1] && st.ch[1].mode == ccpc_pkg::MODE_TOGGLE
		&& !(wr_in && addr_in == ccpc_pkg::ADDR_CH2_CONTROL)
		|=> unit_out_out[1] != $past(unit_out_out[1]) && unit_interrupt_flag_out[1])
		else $error("channel two toggle on match failed");
	a_ch2_mode_off: assert property (
		wr_in && addr_in == ccpc_pkg::ADDR_CH2_CONTROL && wdata_in[3:0] == ccpc_pkg::MODE_OFF
		|=> !unit_out_out[1]) else $error("channel two mode zero did not reset output");
	a_ch2_prescale4: assert property (
		cap_fire[1] && st.ch[1].mode == ccpc_pkg::MODE_CAP_RISE4
		|-> st.ch[1].pre == ccpc_pkg::CAP_DIV4_LAST)
		else $error("channel two fourth edge capture on wrong edge");
	a_ch2_prescale16: assert property (
		cap_fire[1] && st.ch[1].mode == ccpc_pkg::MODE_CAP_RISE16
		|-> st.ch[1].pre == ccpc_pkg::CAP_DIV16_LAST)
		else $error("channel two sixteenth edge capture on wrong edge");
	a_ch2_off_quiet: assert property (
		st.ch[1].mode == ccpc_pkg::MODE_OFF && !(wr_in && addr_in == ccpc_pkg::ADDR_CH2_CONTROL)
		|=> !unit_interrupt_flag_out[1]) else $error("channel two mode zero raised a flag");
	a_ch2_pwm_period: assert property (
		pwm_roll[1] && !(wr_in && addr_in == ccpc_pkg::ADDR_CH2_CONTROL)
		|=> unit_out_out[1] == (st.ch[1].duty != 10'h000))
		else $error("channel two PWM period end actions missing");
	a_ch2_match_tmr: assert property (
		match_fire[1] |-> st.tsel[3:2] != 2'b00)
		else $error("channel two matched without a timer");
	a_ch2_value_read: assert property (
		rd_in && addr_in == ccpc_pkg::ADDR_CH2_VALUE_HI
		|=> rdata_out == $past(st.ch[1].value[15:8]))
		else $error("channel two high byte read wrong");
	a_ch2_capsrc_read: assert property (
		rd_in && addr_in == ccpc_pkg::ADDR_CH2_CAPSRC |=> rdata_out[7:4] == 4'h0)
		else $error("channel two source upper bits not zero");

	// First channel, remaining obligations
	a_ch1_pin: assert property (
		!st.ch[0].en |-> !unit_oe_out[0])
		else $error("channel one pin driven while disabled");
	a_prescale_16: assert property (
		cap_fire[0] && st.ch[0].mode == ccpc_pkg::MODE_CAP_RISE16
		|-> st.ch[0].pre == ccpc_pkg::CAP_DIV16_LAST)
		else $error("sixteenth edge capture on wrong edge");
	a_ch1_off_quiet: assert property (
		st.ch[0].mode == ccpc_pkg::MODE_OFF && !(wr_in && addr_in == ccpc_pkg::ADDR_CH1_CONTROL)
		|=> !unit_interrupt_flag_out[0]) else $error("channel one mode zero raised a flag");
	a_fall_capture: assert property (
		cap_fire[0] && st.ch[0].mode == ccpc_pkg::MODE_CAP_FALL |=> unit_interrupt_flag_out[0])
		else $error("falling edge capture raised no flag");
	a_match_tmr: assert property (
		match_fire[0] |-> st.tsel[1:0] != 2'b00)
		else $error("channel one matched without a timer");
	a_value_lo_read: assert property (
		rd_in && addr_in == ccpc_pkg::ADDR_CH1_VALUE_LO
		|=> rdata_out == $past(st.ch[0].value[7:0]))
		else $error("channel one low byte read wrong");
	a_value_hi_read: assert property (
		rd_in && addr_in == ccpc_pkg::ADDR_CH1_VALUE_HI
		|=> rdata_out == $past(st.ch[0].value[15:8]))
		else $error("channel one high byte read wrong");
	a_capsrc_read: assert property (
		rd_in && addr_in == ccpc_pkg::ADDR_CH1_CAPSRC |=> rdata_out[7:4] == 4'h0)
		else $error("channel one source upper bits not zero");

	// Shared register and timer side
	a_tsel_read: assert property (
		rd_in && addr_in == ccpc_pkg::ADDR_TIMER_SEL |=> rdata_out == $past(st.tsel))
		else $error("timer selection read wrong");
	a_pwm_select: assert property (
		wr_in && addr_in == ccpc_pkg::ADDR_TIMER_SEL
		|=> pwm_timer_select_out == $past(wdata_in[7:4]))
		else $error("standalone PWM timer select not taken");
	a_read_idle: assert property (
		!rd_in |=> rdata_out == 8'h00)
		else $error("read data present without a read");
	a_t16_clear_idle: assert property (
		!(|match_fire) |=> timer16_clear_out == 3'h0)
		else $error("timer clear without a match");
	a_t8_clear_idle: assert property (
		!(|pwm_roll) |=> timer8_clear_out == 3'h0)
		else $error("period timer clear without period end");

endmodule // ccpc_unit

// ---- tb/ccpc_far.sv ----
// Timers on the far side: 16-bit timers count every cycle, 8-bit timers step once every four
module ccpc_far (
	input  wire logic                     mclk_in,
	input  wire logic                     load_in,
	input  wire logic [7:0]               period_in,
	input  wire logic [2:0]               clear16_in,
	input  wire logic [2:0]               clear8_in,
	output logic      [2:0][15:0]         timer16_out,
	output ccpc_pkg::ccpc_tmr8_type [2:0] timer8_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase = 2'h0;
	logic [7:0] cnt   = 8'h00;
	always_ff @(posedge mclk_in)
	begin
		phase <= phase + 2'h1;
		if (|clear8_in)
			cnt <= 8'h00;
		else if (phase == 2'h3)
			cnt <= (cnt == period_in) ? 8'h00 : cnt + 8'h01;
		for (int i = 0; i < 3; i++)
		begin
			// Load holds each timer at a distinct value so the selected one can be told apart
			if (load_in || clear16_in[i])
				timer16_out[i] <= 16'((i + 1) * 16'h1000);
			else
				timer16_out[i] <= timer16_out[i] + 16'h0001;
		end
	end
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			timer8_out[i] = '{cnt, period_in, phase, phase == 2'h3};
	end
endmodule // ccpc_far

// ---- tb/tb_ccpc_unit.sv ----
module tb_ccpc_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic                         mclk_in = 1'b0;
	logic                         nrst_in = 1'b0;
	logic [11:0]                  addr_in = 12'h000;
	logic [7:0]                   wdata_in = 8'h00;
	logic                         wr_in = 1'b0;
	logic                         rd_in = 1'b0;
	logic                         load = 1'b1;
	logic [15:0]                  srcs = 16'h0000;
	logic [7:0]                   rdata_out;
	logic [2:0][15:0]             t16;
	ccpc_pkg::ccpc_tmr8_type [2:0] t8;
	logic [1:0]                   out, oe, flag;
	logic [2:0]                   clr16, clr8;
	logic [3:0]                   psel;
	int                           failures = 0;
	int                           samples_checked = 0;
	int                           n, m, f, h0;
	logic [3:0] cap_m [5] = '{4'h5, 4'h4, 4'h3, 4'h6, 4'h7};
	int         cap_k [5] = '{4, 4, 4, 4, 16};
	int         cap_e [5] = '{4, 4, 8, 1, 1};
	int         src_b [6] = '{0, 1, 2, 3, 8, 15};
	logic [3:0] cmp_m [6] = '{4'h8, 4'h2, 4'h1, 4'h9, 4'ha, 4'hb};
	logic [5:0] cmp_o = 6'b110101;
	logic [5:0] cmp_n = 6'b000101;
	logic [5:0] cmp_c = 6'b100100;

	always #12.5 mclk_in = ~mclk_in;

	ccpc_far far_u (.mclk_in(mclk_in), .load_in(load), .period_in(8'h03), .clear16_in(clr16),
		.clear8_in(clr8), .timer16_out(t16), .timer8_out(t8));

	ccpc_unit dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.timer16_in(t16), .timer8_in(t8), .pin_select_in({1'b0, srcs[0]}),
		.comparator_in(srcs[2:1]), .interrupt_on_change_in(srcs[3]),
		.logic_cell_in(srcs[15:8]), .unit_out_out(out), .unit_oe_out(oe),
		.unit_interrupt_flag_out(flag), .timer16_clear_out(clr16), .timer8_clear_out(clr8),
		.pwm_timer_select_out(psel));

	task automatic give_verdict();
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1;
		chk(16'(rdata_out), 16'(e));
	endtask

	// Bounded wait so a missing match shows up as a mismatch instead of a hang
	task automatic wait_flag();
		n = 0;
		do
		begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		while (flag[0] !== 1'b1 && n < 200);
		if (n >= 200)
			chk(16'h0000, 16'h0001);
	endtask

	task automatic pulses(input int b, input int k);
		n = 0;
		for (int j = 0; j < 8 * k + 8; j++)
		begin
			@(posedge mclk_in);
			if (j < 8 * k && j % 4 == 0)
				srcs[b] <= ~srcs[b];
			#1;
			if (flag[0] === 1'b1)
				n++;
		end
	endtask

	// Sixty-four cycles span exactly four periods, so the start phase does not matter
	task automatic measure();
		n = 0;
		m = 0;
		f = 0;
		repeat (32) @(posedge mclk_in);
		repeat (64)
		begin
			@(posedge mclk_in);
			#1;
			n += int'(out[0] === 1'b1);
			m += int'(clr8[0] === 1'b1);
			f += int'(flag[0] === 1'b1);
		end
	endtask

	initial
	begin
		repeat (19) @(posedge mclk_in);
		chk(16'(psel), 16'h0005);
		chk(16'(oe), 16'h0000);
		@(posedge mclk_in);
		nrst_in <= 1'b1;
		rd(ccpc_pkg::ADDR_TIMER_SEL, 8'h55);
		rd(ccpc_pkg::ADDR_CH1_CONTROL, 8'h00);
		rd(ccpc_pkg::ADDR_CH2_CAPSRC, 8'h00);
		rd(ccpc_pkg::ADDR_CH2_VALUE_LO, 8'h00);
		rd(12'hfa4, 8'h00);
		wr(12'hfae, 8'hff);
		rd(12'hfae, 8'h00);
		wr(ccpc_pkg::ADDR_CH2_CONTROL, 8'h7f);
		rd(ccpc_pkg::ADDR_CH2_CONTROL, 8'h1f);
		chk(16'(oe), 16'h0000);
		wr(ccpc_pkg::ADDR_CH2_CAPSRC, 8'hff);
		rd(ccpc_pkg::ADDR_CH2_CAPSRC, 8'h0f);
		wr(ccpc_pkg::ADDR_CH2_VALUE_LO, 8'h34);
		wr(ccpc_pkg::ADDR_CH2_VALUE_HI, 8'h12);
		rd(ccpc_pkg::ADDR_CH2_VALUE_LO, 8'h34);
		rd(ccpc_pkg::ADDR_CH2_VALUE_HI, 8'h12);
		for (int i = 0; i < 5; i++)
		begin
			wr(ccpc_pkg::ADDR_CH1_CONTROL, {4'h8, cap_m[i]});
			pulses(0, cap_k[i]);
			chk(16'(n), 16'(cap_e[i]));
		end
		wr(ccpc_pkg::ADDR_CH1_CONTROL, 8'h85);
		for (int i = 0; i < 6; i++)
		begin
			wr(ccpc_pkg::ADDR_CH1_CAPSRC, 8'(src_b[i]));
			pulses(src_b[i], 2);
			chk(16'(n), 16'h0002);
		end
		wr(ccpc_pkg::ADDR_CH1_CAPSRC, 8'h00);
		rd(ccpc_pkg::ADDR_CH1_VALUE_HI, 8'h10);
		wr(ccpc_pkg::ADDR_TIMER_SEL, 8'h56);
		pulses(0, 1);
		chk(16'(n), 16'h0001);
		rd(ccpc_pkg::ADDR_CH1_VALUE_HI, 8'h20);
		wr(ccpc_pkg::ADDR_TIMER_SEL, 8'h55);
		wr(ccpc_pkg::ADDR_CH1_VALUE_LO, 8'h10);
		wr(ccpc_pkg::ADDR_CH1_VALUE_HI, 8'h10);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge mclk_in);
			load <= 1'b1;
			@(posedge mclk_in);
			load <= 1'b0;
			wr(ccpc_pkg::ADDR_CH1_CONTROL, {4'h8, cmp_m[i]});
			wait_flag();
			chk(16'(out[0]), 16'(cmp_o[i]));
			chk(16'(clr16[0]), 16'(cmp_c[i]));
			chk(16'(oe[0]), 16'h0001);
			@(posedge mclk_in);
			#1;
			chk(16'(out[0]), 16'(cmp_n[i]));
		end
		wr(ccpc_pkg::ADDR_CH1_CONTROL, 8'h88);
		wait_flag();
		rd(ccpc_pkg::ADDR_CH1_CONTROL, 8'ha8);
		wr(ccpc_pkg::ADDR_CH1_CONTROL, 8'h80);
		rd(ccpc_pkg::ADDR_CH1_CONTROL, 8'h80);
		wr(ccpc_pkg::ADDR_TIMER_SEL, 8'he5);
		#1;
		chk(16'(psel), 16'h000e);
		wr(ccpc_pkg::ADDR_CH1_VALUE_LO, 8'h06);
		wr(ccpc_pkg::ADDR_CH1_VALUE_HI, 8'h00);
		wr(ccpc_pkg::ADDR_CH1_CONTROL, 8'h8c);
		measure();
		h0 = n;
		chk(16'(n), 16'h0018);
		chk(16'(m), 16'h0004);
		chk(16'(f), 16'h0004);
		wr(ccpc_pkg::ADDR_CH1_VALUE_HI, 8'h02);
		wr(ccpc_pkg::ADDR_CH1_VALUE_LO, 8'h80);
		wr(ccpc_pkg::ADDR_CH1_CONTROL, 8'h9c);
		measure();
		chk(16'(n - h0), 16'h0010);
		wr(ccpc_pkg::ADDR_CH1_VALUE_HI, 8'h00);
		wr(ccpc_pkg::ADDR_CH1_VALUE_LO, 8'h00);
		measure();
		chk(16'(n), 16'h0000);
		@(posedge mclk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
		rd(ccpc_pkg::ADDR_TIMER_SEL, 8'h55);
		rd(ccpc_pkg::ADDR_CH1_CONTROL, 8'h00);
		give_verdict();
	end

	// The sequence needs about a thousand cycles; this bound is far above that
	initial
	begin
		#(20000 * 25);
		failures++;
		give_verdict();
	end
endmodule // tb_ccpc_unit
